//--- logic/avb_stats_pkg.sv
// Purpose: Shared constants and carriers for the bridging rx stream and tx statistics
// Assumes: One clock domain, clk_sys, which is also the receive client clock
// Notes:   Vector bit layout follows the packed struct order, bit 31 first
package avb_stats_pkg;
  localparam int unsigned CLK_MHZ        = 25;
  localparam int unsigned DATA_W         = 8;
  localparam int unsigned FIFO_DEPTH     = 16;
  localparam int unsigned SYNC_STAGES    = 2;
  localparam int unsigned ADDR_BYTES     = 6;
  localparam int unsigned TYPE_HI_IDX    = 12;
  localparam int unsigned TYPE_LO_IDX    = 13;
  localparam logic [14:0] LEN_CEIL       = 15'h41c6; // 16838, above the 14-bit field
  localparam logic [13:0] LEN_FIELD_MAX  = 14'h3fff;
  localparam logic [15:0] CTRL_TYPE      = 16'h8808;
  localparam logic [15:0] VLAN_TYPE      = 16'h8100;
  localparam logic [7:0]  BCAST_BYTE     = 8'hff;
  localparam logic [3:0]  ATTEMPTS_FD    = 4'h0;
  localparam logic        CE_RST         = 1'b0;

  typedef struct packed {
    logic       last;
    logic       error;
    logic [7:0] data;
  } rx_word_t;

  typedef struct packed {
    logic        pause_sent;
    logic        byte_valid;
    logic        rsvd29;
    logic [3:0]  attempts;
    logic        rsvd24;
    logic        excess_col;
    logic        late_col;
    logic        defer_limit_flag;
    logic        deferred;
    logic        tagged_flag;
    logic [13:0] frame_len;
    logic        control;
    logic        underrun;
    logic        multicast;
    logic        broadcast;
    logic        sent_ok_flag;
  } tx_stats_t;

  localparam tx_stats_t STATS_RST = '0;
endpackage : avb_stats_pkg

//--- logic/avb_rx_stream_and_tx_stats.sv
// Purpose: Bridging receive byte stream toward stream logic, and tx statistics vector
// Assumes: MAC client byte, enable and good/bad strobes are on clk_sys
// Notes:   Stream clock is clk_sys itself; the stream enable is avb_rx_ce
//
// Overview of operation
// R01 - Stream clock from rx clock, enable-qualified valid
// R02 - Enable every cycle gigabit, alternate at 100M
// R03 - Stream clock 125 MHz gigabit, 25 MHz 100M; here the stream clock is clk_sys at both rates
// R04 - Fresh byte on every valid cycle
// R05 - Partner cannot stall, always ready
// R06 - Valid low after penultimate until good/bad
// R07 - One enabled cycle with final byte, last
// R08 - Error high for bad, low for good
// R09 - Forward every address-matched frame, good or bad
// R10 - Tx vector of 32 bits, one cycle
// R11 - Vector only toward internal counters
// R12 - Half-duplex bits 28..20 driven zero
// R13 - Bit 31 marks requested pause frame
// R14 - Bit 30 follows byte transmission every cycle
// R15 - Reserved bits 29 and 24 zero
// R16 - Attempts field zero in full duplex
// R17 - Bit 19 VLAN tag when VLAN enabled
// R18 - Bits 18..5 byte length, saturating
// R19 - Bit 4 control type 0x8808
// R20 - Bit 3 underrun
// R21 - Bit 2 multicast, bit 1 broadcast
// R22 - Bit 0 sent without error
// R23 - One-cycle valid with the vector
`timescale 1ns/100ps

module avb_byte_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem[rd_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg  <= push ? AW'(wr_reg + 1'b1) : wr_reg;
      rd_reg  <= pop ? AW'(rd_reg + 1'b1) : rd_reg;
      cnt_reg <= (AW+1)'(cnt_reg + push - pop);
    end
  end
endmodule : avb_byte_fifo

module avb_rx_stream_and_tx_stats
  import avb_stats_pkg::*;
(
  // Clock and reset
  input  wire logic            clk_sys,
  input  wire logic            rst,
  // Link speed strap, from outside the domain
  input  wire logic            speed_gig,
  // Receive client side of the MAC
  input  wire logic [7:0]      rx_data,
  input  wire logic            rx_byte_en,
  input  wire logic            rx_addr_match,
  input  wire logic            rx_good,
  input  wire logic            rx_bad,
  // Bridging receive stream
  output logic                 avb_rx_ce,
  output logic                 avb_rx_valid,
  output logic [7:0]           avb_rx_data,
  output logic                 avb_rx_last,
  output logic                 avb_rx_error,
  output logic                 rx_overflow,
  // Transmit engine observation
  input  wire logic [7:0]      tx_data,
  input  wire logic            tx_byte_valid,
  input  wire logic            tx_frame_done,
  input  wire logic            tx_underrun,
  input  wire logic            tx_pause_sent,
  input  wire logic            tx_vlan_en,
  // Statistics toward internal counters
  output avb_stats_pkg::tx_stats_t tx_stats,
  output logic                 tx_stats_valid
);
  import avb_stats_pkg::*;

  logic [SYNC_STAGES-1:0] gig_sync_reg;
  logic                   ce_reg;
  logic                   ce_next;
  logic                   hold_valid_reg;
  logic [7:0]             hold_data_reg;
  logic                   in_frame_reg;
  logic                   fifo_in_valid;
  logic                   fifo_in_ready;
  rx_word_t               fifo_in;
  logic                   fifo_out_valid;
  rx_word_t               fifo_out;
  logic                   pop;
  logic                   valid_reg;
  logic [7:0]             data_reg;
  logic                   last_reg;
  logic                   error_reg;
  logic                   ovf_reg;
  logic                   rx_end;

  // Speed pin is asynchronous to the client clock
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gig_sync_reg <= '0;
    end else begin
      gig_sync_reg <= {gig_sync_reg[0], speed_gig};
    end
  end

  // At 100M the enable alternates; the stream clock is clk_sys at either rate
  assign ce_next = gig_sync_reg[1] ? 1'b1 : ~ce_reg; // R02 R03
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ce_reg <= CE_RST;
    end else begin
      ce_reg <= ce_next; // R01
    end
  end

  // Newest byte is held back so the last one can wait for the verdict
  assign rx_end        = in_frame_reg && (rx_good || rx_bad);
  assign fifo_in_valid = (rx_byte_en && rx_addr_match && hold_valid_reg) || rx_end; // R06 R09
  assign fifo_in.data  = hold_data_reg;
  assign fifo_in.last  = rx_end; // R07
  assign fifo_in.error = rx_end && rx_bad; // R08

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hold_valid_reg <= 1'b0;
      hold_data_reg  <= '0;
      in_frame_reg   <= 1'b0;
    end else if (rx_end) begin
      hold_valid_reg <= 1'b0;
      in_frame_reg   <= 1'b0;
    end else if (rx_byte_en && rx_addr_match) begin
      hold_valid_reg <= 1'b1; // R09
      hold_data_reg  <= rx_data;
      in_frame_reg   <= 1'b1;
    end
  end

  // The partner cannot stall, so a full buffer can only be reported
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ovf_reg <= 1'b0;
    end else begin
      ovf_reg <= fifo_in_valid && !fifo_in_ready; // R05
    end
  end

  avb_byte_fifo #(
    .WIDTH ($bits(rx_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (fifo_out_valid),
    .out_ready (ce_next),
    .out_data  (fifo_out)
  );

  assign pop = ce_next && fifo_out_valid;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      valid_reg <= 1'b0;
      data_reg  <= '0;
      last_reg  <= 1'b0;
      error_reg <= 1'b0;
    end else begin
      valid_reg <= pop; // R04
      data_reg  <= pop ? fifo_out.data : data_reg;
      last_reg  <= pop && fifo_out.last; // R07
      error_reg <= pop && fifo_out.last && fifo_out.error; // R08
    end
  end

  assign avb_rx_ce    = ce_reg;
  assign avb_rx_valid = valid_reg;
  assign avb_rx_data  = data_reg;
  assign avb_rx_last  = last_reg;
  assign avb_rx_error = error_reg;
  assign rx_overflow  = ovf_reg;

  valid_on_enable_a: assert property (@(posedge clk_sys) disable iff (rst) // R01
    avb_rx_valid |-> avb_rx_ce) else $error("stream valid outside enable");
  half_rate_ce_a: assert property (@(posedge clk_sys) disable iff (rst) // R02
    !gig_sync_reg[1] && $stable(gig_sync_reg[1]) |=> avb_rx_ce != $past(avb_rx_ce))
    else $error("enable not alternating at 100M");
  gig_rate_ce_a: assert property (@(posedge clk_sys) disable iff (rst) // R02
    gig_sync_reg[1] && $past(gig_sync_reg[1]) |=> avb_rx_ce)
    else $error("enable dropped at gigabit");
  error_only_last_a: assert property (@(posedge clk_sys) disable iff (rst) // R08
    avb_rx_error |-> avb_rx_last && avb_rx_valid) else $error("error outside last");
  last_needs_verdict_a: assert property (@(posedge clk_sys) disable iff (rst) // R06
    fifo_in_valid && fifo_in.last |-> rx_good || rx_bad) else $error("last without verdict");
  verdict_ends_hold_a: assert property (@(posedge clk_sys) disable iff (rst) // R07
    rx_end |=> !hold_valid_reg && !in_frame_reg) else $error("held byte kept");
  // Full buffer drains at half rate, so the flagged byte is out within 40 cycles
  bad_sets_error_a: assert property (@(posedge clk_sys) disable iff (rst) // R08
    rx_end && rx_bad && fifo_in_ready |-> ##[1:40] avb_rx_error)
    else $error("bad frame not flagged");

  // Transmit statistics, built by watching the bytes going out
  logic [14:0] len_reg;
  logic        mcast_reg;
  logic        bcast_reg;
  logic [7:0]  type_hi_reg;
  logic        ctrl_reg;
  logic        vlan_reg;
  tx_stats_t   stats_reg;
  tx_stats_t   stats_next;
  logic        stats_valid_reg;
  logic [15:0] type_word;

  assign type_word = {type_hi_reg, tx_data};

  always_ff @(posedge clk_sys) begin
    if (rst || tx_frame_done) begin
      len_reg     <= '0;
      mcast_reg   <= 1'b0;
      bcast_reg   <= 1'b1;
      type_hi_reg <= '0;
      ctrl_reg    <= 1'b0;
      vlan_reg    <= 1'b0;
    end else if (tx_byte_valid) begin
      len_reg <= (len_reg >= LEN_CEIL) ? LEN_CEIL : 15'(len_reg + 1'b1); // R18
      if (len_reg == '0) begin
        mcast_reg <= tx_data[0]; // R21
      end
      if (len_reg < 15'(ADDR_BYTES)) begin
        bcast_reg <= bcast_reg && (tx_data == BCAST_BYTE); // R21
      end
      if (len_reg == 15'(TYPE_HI_IDX)) begin
        type_hi_reg <= tx_data;
      end
      if (len_reg == 15'(TYPE_LO_IDX)) begin
        ctrl_reg <= (type_word == CTRL_TYPE); // R19
        vlan_reg <= (type_word == VLAN_TYPE);
      end
    end
  end

  always_comb begin
    stats_next                  = stats_reg;
    stats_next.byte_valid       = tx_byte_valid; // R14
    stats_next.rsvd29           = 1'b0; // R15
    stats_next.rsvd24           = 1'b0; // R15
    stats_next.attempts         = ATTEMPTS_FD; // R16
    stats_next.excess_col       = 1'b0; // R12
    stats_next.late_col         = 1'b0; // R12
    stats_next.defer_limit_flag = 1'b0; // R12
    stats_next.deferred         = 1'b0; // R12
    if (tx_frame_done) begin
      stats_next.pause_sent   = tx_pause_sent; // R13
      stats_next.tagged_flag  = vlan_reg && tx_vlan_en; // R17
      stats_next.frame_len    = (len_reg > 15'(LEN_FIELD_MAX)) ? LEN_FIELD_MAX
                                                               : len_reg[13:0]; // R18
      stats_next.control      = ctrl_reg; // R19
      stats_next.underrun     = tx_underrun; // R20
      stats_next.multicast    = mcast_reg && !bcast_reg; // R21
      stats_next.broadcast    = bcast_reg && (len_reg >= 15'(ADDR_BYTES)); // R21
      stats_next.sent_ok_flag = !tx_underrun; // R22
    end
  end

  // Vector leaves only toward the counter block, never a register map
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stats_reg       <= STATS_RST;
      stats_valid_reg <= 1'b0;
    end else begin
      stats_reg       <= stats_next; // R10 R11
      stats_valid_reg <= tx_frame_done; // R23
    end
  end

  assign tx_stats       = stats_reg;
  assign tx_stats_valid = stats_valid_reg;

  sequence frame_closed_s;
    tx_frame_done ##1 tx_stats_valid;
  endsequence

  stats_pulse_a: assert property (@(posedge clk_sys) disable iff (rst) // R23
    tx_frame_done |-> frame_closed_s) else $error("stats valid missing after done");
  stats_single_a: assert property (@(posedge clk_sys) disable iff (rst) // R10
    tx_stats_valid |-> $past(tx_frame_done)) else $error("stats valid without done");
  half_duplex_zero_a: assert property (@(posedge clk_sys) disable iff (rst) // R12 R16
    tx_stats.attempts == '0 && !tx_stats.excess_col && !tx_stats.late_col
    && !tx_stats.defer_limit_flag && !tx_stats.deferred) else $error("half duplex bit set");
  reserved_zero_a: assert property (@(posedge clk_sys) disable iff (rst) // R15
    !tx_stats.rsvd29 && !tx_stats.rsvd24) else $error("reserved bit set");
  byte_valid_follow_a: assert property (@(posedge clk_sys) disable iff (rst) // R14
    tx_stats.byte_valid == $past(tx_byte_valid)) else $error("byte valid bit lags");
  ok_vs_underrun_a: assert property (@(posedge clk_sys) disable iff (rst) // R20 R22
    frame_closed_s |-> tx_stats.sent_ok_flag != tx_stats.underrun)
    else $error("ok and underrun agree");
  length_capped_a: assert property (@(posedge clk_sys) disable iff (rst) // R18
    len_reg <= LEN_CEIL) else $error("length counter past ceiling");
endmodule : avb_rx_stream_and_tx_stats

//--- verification/avb_stream_sink.sv
// Purpose: Far-side stream logic that takes every offered byte
// Assumes: Stream clock is clk_sys; avb_rx_ce qualifies avb_rx_valid
// Notes:   No backpressure path exists, so none is modelled
`timescale 1ns/100ps
module avb_stream_sink
  import avb_stats_pkg::*;
(
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst,
  // Stream from the device
  input  wire logic               avb_rx_ce,
  input  wire logic               avb_rx_valid,
  input  wire logic [7:0]         avb_rx_data,
  input  wire logic               avb_rx_last,
  input  wire logic               avb_rx_error,
  // Captured words
  output avb_stats_pkg::rx_word_t word,
  output logic                    word_valid,
  output logic                    stray
);
  // Always ready: every enabled byte is taken
  always_ff @(posedge clk_sys) begin
    word_valid <= !rst && avb_rx_ce && avb_rx_valid;
    word       <= '{last: avb_rx_last, error: avb_rx_error, data: avb_rx_data};
    stray      <= !rst && avb_rx_valid && !avb_rx_ce;
  end
endmodule : avb_stream_sink

//--- verification/avb_rx_stream_and_tx_stats_tb_top.sv
// Purpose: Self-checking bench for the bridging rx stream and tx statistics
// Assumes: Inputs change on the falling edge of clk_sys
// Notes:   Overflow frame contents are not predicted, only the flag
`timescale 1ns/100ps
module avb_rx_stream_and_tx_stats_tb_top;
  import avb_stats_pkg::*;
  logic       clk_sys, rst, speed_gig, rx_byte_en, rx_addr_match, rx_good, rx_bad;
  logic [7:0] rx_data, tx_data, avb_rx_data;
  logic       tx_byte_valid, tx_frame_done, tx_underrun, tx_pause_sent, tx_vlan_en;
  logic       avb_rx_ce, avb_rx_valid, avb_rx_last, avb_rx_error, rx_overflow;
  logic       tx_stats_valid, word_valid, stray, done_d, lossy, saw_ovf, ce0;
  tx_stats_t  tx_stats;
  rx_word_t   word;
  rx_word_t   rx_q[$];
  tx_stats_t  tx_q[$];
  int         failures, comparisons;

  avb_rx_stream_and_tx_stats DUT (.clk_sys(clk_sys), .rst(rst), .speed_gig(speed_gig),
    .rx_data(rx_data), .rx_byte_en(rx_byte_en), .rx_addr_match(rx_addr_match),
    .rx_good(rx_good), .rx_bad(rx_bad), .avb_rx_ce(avb_rx_ce), .avb_rx_valid(avb_rx_valid),
    .avb_rx_data(avb_rx_data), .avb_rx_last(avb_rx_last), .avb_rx_error(avb_rx_error),
    .rx_overflow(rx_overflow), .tx_data(tx_data), .tx_byte_valid(tx_byte_valid),
    .tx_frame_done(tx_frame_done), .tx_underrun(tx_underrun), .tx_pause_sent(tx_pause_sent),
    .tx_vlan_en(tx_vlan_en), .tx_stats(tx_stats), .tx_stats_valid(tx_stats_valid));

  avb_stream_sink sink (.clk_sys(clk_sys), .rst(rst), .avb_rx_ce(avb_rx_ce),
    .avb_rx_valid(avb_rx_valid), .avb_rx_data(avb_rx_data), .avb_rx_last(avb_rx_last),
    .avb_rx_error(avb_rx_error), .word(word), .word_valid(word_valid), .stray(stray));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  task automatic rx_frame(input int n, input logic bad, input logic match, input int gap);
    logic [7:0] b;
    rx_addr_match = match;
    for (int i = 0; i < n; i++) begin
      b = 8'($urandom);
      rx_data = b;
      rx_byte_en = 1'b1;
      if (match) rx_q.push_back('{last: i == n - 1, error: i == n - 1 && bad, data: b});
      @(negedge clk_sys);
      if (gap > 0) begin
        rx_byte_en = 1'b0;
        repeat (gap) @(negedge clk_sys);
      end
    end
    rx_byte_en = 1'b0;
    rx_good = !bad;
    rx_bad = bad;
    @(negedge clk_sys);
    rx_good = 1'b0;
    rx_bad = 1'b0;
    repeat (8) @(negedge clk_sys);
  endtask : rx_frame

  task automatic tx_frame(input logic [47:0] da, input logic [15:0] ty, input int n,
                          input logic ur, input logic ps);
    tx_stats_t e;
    e = '0;
    tx_byte_valid = 1'b1;
    for (int i = 0; i < n; i++) begin
      tx_data = (i < 6) ? da[47-8*i -: 8] : (i == 12) ? ty[15:8] : (i == 13) ? ty[7:0]
              : 8'($urandom);
      @(negedge clk_sys);
      if (i == 3) check(32'(tx_stats.byte_valid), 1);
    end
    tx_byte_valid = 1'b0;
    tx_frame_done = 1'b1;
    tx_underrun = ur;
    tx_pause_sent = ps;
    e.pause_sent = ps;
    e.tagged_flag = tx_vlan_en && ty == VLAN_TYPE;
    e.frame_len = (n > 16383) ? LEN_FIELD_MAX : 14'(n);
    e.control = ty == CTRL_TYPE;
    e.underrun = ur;
    e.broadcast = da == '1;
    e.multicast = da[40] && !e.broadcast;
    e.sent_ok_flag = !ur;
    tx_q.push_back(e);
    @(negedge clk_sys);
    tx_frame_done = 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask : tx_frame

  // Results are matched against the oldest note as they appear
  always @(posedge clk_sys) begin
    done_d <= tx_frame_done;
    if (rx_overflow) saw_ovf <= 1'b1;
    if (stray) check(32'(stray), 0);
    if (word_valid && !lossy) begin
      if (rx_q.size() == 0) check(32'hbad, 0);
      else check(32'(word), 32'(rx_q.pop_front()));
    end
    if (tx_stats_valid) begin
      check(32'(done_d), 1);
      check(32'(tx_stats), 32'(tx_q.pop_front()));
    end
  end

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  initial begin
    #(40 * 40000);
    failures++;
    print_verdict();
  end

  initial begin
    void'($urandom(32'he6fa));
    {rst, speed_gig, rx_data, rx_byte_en, rx_addr_match, rx_good, rx_bad} = 14'h2000;
    {tx_data, tx_byte_valid, tx_frame_done, tx_underrun, tx_pause_sent} = '0;
    {tx_vlan_en, lossy, saw_ovf, failures, comparisons} = '0;
    repeat (8) @(negedge clk_sys);
    rst = 1'b0;
    check(32'({avb_rx_valid, tx_stats_valid}), 0);
    for (int s = 0; s < 2; s++) begin
      speed_gig = s[0];
      repeat (4) @(negedge clk_sys);
      ce0 = avb_rx_ce;
      @(negedge clk_sys);
      check(32'(s ? avb_rx_ce & ce0 : avb_rx_ce ^ ce0), 1);
      for (int v = 0; v < 2; v++) rx_frame(3 + $urandom_range(4), v[0], 1'b1, 1 - s);
      rx_frame(5, 1'b0, 1'b0, 1 - s);
    end
    // Back-to-back bytes at 100M outrun the drain and fill the buffer
    speed_gig = 1'b0;
    repeat (4) @(negedge clk_sys);
    lossy = 1'b1;
    rx_frame(40, 1'b0, 1'b1, 0);
    repeat (80) @(negedge clk_sys);
    rx_q.delete();
    lossy = 1'b0;
    check(32'(saw_ovf), 1);
    rx_frame(4, 1'b1, 1'b1, 1);
    tx_vlan_en = 1'b1;
    tx_frame(48'hffffffffffff, 16'h0800, 64, 1'b0, 1'b0);
    tx_frame(48'h0180c2000001, CTRL_TYPE, 60, 1'b0, 1'b1);
    tx_frame(48'h020000000001, VLAN_TYPE, 68, 1'b1, 1'b0);
    tx_vlan_en = 1'b0;
    tx_frame(48'h020000000001, VLAN_TYPE, 16400, 1'b0, 1'b0);
    check(32'(rx_q.size() + tx_q.size()), 0);
    print_verdict();
  end
endmodule : avb_rx_stream_and_tx_stats_tb_top
